// ---- core/tfs_status_flags.sv ----
// status flags and ideality selection of an eight-channel temperature monitor
// assumes a conversion sequencer delivering one result per channel with a done pulse,
// and a bus front end giving one-cycle read and write strobes with an 8-bit address
//
// Summary of operation
// - local over-temperature sets overtemp bit 7.
// - remote channels 7..1 over-temperature set overtemp bits 6..0.
// - open or supply-tied diode on channel 7..1 sets fault bits 6..0; bit 7 reserved.
// - low alert: bit 7 for channel 7, bits 5..0 for channels 6..1.
// - low-alert bit 6 flags local channel below its low limit.
// - remote channels default to ideality 1.008.
// - host can write an ideality register to program another value.
// - per-channel select picks default or programmed ideality.
// - overtemp bit clears only below limit minus 32 degree hysteresis.
// - low-alert bits clear on read, set again by next conversion if still true.
// - ideality code uses low five bits: 0.999 plus 0.001 per step.
`timescale 1ns/1ns
module tfs_status_flags
    import tfs_pkg::*;
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    // conversion result; channel 0 is local, 1..7 remote
    input wire logic CONV_DONE_I,
    input wire logic [2:0] CONV_CH_I,
    input wire logic [10:0] CONV_TEMP_I,
    input wire logic [10:0] OVT_LIMIT_I,
    input wire logic [10:0] LOW_LIMIT_I,
    input wire logic DIODE_OPEN_I,
    input wire logic ANODE_AT_SUPPLY_I,
    // register port
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // ideality for the channel being converted, in thousandths
    output logic [10:0] IDEALITY_MILLI_O
);
    logic [7:0] ovt_r;
    logic [7:0] fault_r;
    logic [7:0] low_r;
    logic [7:0] ideality_r;
    logic [7:0] ideal_sel_r;
    logic [7:0] rdata_r;
    logic [10:0] ideal_r;
    logic [2:0] ovt_bit;
    logic [2:0] low_bit;
    logic is_local;
    logic over;
    logic clear_ok;
    logic under;
    logic low_rd;
    logic [4:0] code;

    assign is_local = (CONV_CH_I == 3'(LOCAL_CH));
    // local in msb, remote n in bit n-1
    assign ovt_bit = is_local ? 3'(OVT_LOCAL_BIT) : CONV_CH_I - 3'h1;
    assign low_bit = is_local ? 3'(LOW_LOCAL_BIT) :
        (CONV_CH_I == 3'h7) ? 3'h7 : CONV_CH_I - 3'h1;
    assign over = CONV_TEMP_I > OVT_LIMIT_I;
    // widened so a reading near full scale cannot wrap below the limit
    assign clear_ok = (12'(CONV_TEMP_I) + 12'(HYST_DEG)) < 12'(OVT_LIMIT_I);
    assign under = CONV_TEMP_I < LOW_LIMIT_I;
    assign low_rd = REG_RD_I && (REG_ADDR_I == LOW_ALERT_ADDR);

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ovt_r <= STATUS_RESET;
        end else if (CONV_DONE_I) begin
            if (over) begin
                ovt_r[ovt_bit] <= 1'b1;
            end else if (clear_ok) begin
                ovt_r[ovt_bit] <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            fault_r <= STATUS_RESET;
        end else if (CONV_DONE_I && !is_local) begin
            fault_r[CONV_CH_I - 3'h1] <= DIODE_OPEN_I || ANODE_AT_SUPPLY_I;
        end
    end

    // a set in the read cycle wins over the read clear
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            low_r <= STATUS_RESET;
        end else begin
            if (low_rd) begin
                low_r <= STATUS_RESET;
            end
            if (CONV_DONE_I && under) begin
                low_r[low_bit] <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ideality_r <= IDEALITY_RESET;
            ideal_sel_r <= IDEAL_SEL_RESET;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == IDEALITY_ADDR) begin
                ideality_r <= REG_WDATA_I;
            end
            if (REG_ADDR_I == IDEAL_SEL_ADDR) begin
                ideal_sel_r <= REG_WDATA_I;
            end
        end
    end

    // ideality presented for the channel now in conversion
    assign code = (!is_local && ideal_sel_r[CONV_CH_I - 3'h1]) ?
        ideality_r[IDEAL_CODE_W-1:0] : IDEAL_CODE_DEFAULT;
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            ideal_r <= IDEAL_BASE_MILLI + 11'(IDEAL_CODE_DEFAULT);
        end else begin
            ideal_r <= IDEAL_BASE_MILLI + 11'(code);
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            rdata_r <= 8'h00;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                OVT_STATUS_ADDR: rdata_r <= ovt_r;
                DIODE_FAULT_ADDR: rdata_r <= fault_r;
                LOW_ALERT_ADDR: rdata_r <= low_r;
                IDEALITY_ADDR: rdata_r <= ideality_r;
                IDEAL_SEL_ADDR: rdata_r <= ideal_sel_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign REG_RDATA_O = rdata_r;
    assign IDEALITY_MILLI_O = ideal_r;

    property p_ovt_set;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && over |=> ovt_r[$past(ovt_bit)];
    endproperty
    a_ovt_set: assert property (p_ovt_set) else $error("overtemp bit not set");

    property p_ovt_local;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && is_local && over |=> ovt_r[7];
    endproperty
    a_ovt_local: assert property (p_ovt_local) else $error("local overtemp not in msb");

    property p_ovt_hold;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && !over && !clear_ok && ovt_r[ovt_bit] |=> ovt_r[$past(ovt_bit)];
    endproperty
    a_ovt_hold: assert property (p_ovt_hold) else $error("overtemp cleared in hysteresis");

    property p_fault_rsvd;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !fault_r[FAULT_RSVD_BIT];
    endproperty
    a_fault_rsvd: assert property (p_fault_rsvd) else $error("reserved fault bit set");

    property p_low_clear;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        low_rd && !CONV_DONE_I |=> low_r == 8'h00;
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("low alert not cleared by read");

    property p_low_local;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && is_local && under |=> low_r[6];
    endproperty
    a_low_local: assert property (p_low_local) else $error("local low alert missing");

    property p_low_ch7;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && CONV_CH_I == 3'h7 && under |=> low_r[7];
    endproperty
    a_low_ch7: assert property (p_low_ch7) else $error("channel 7 low alert missing");

    property p_ideal_default;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !is_local && !ideal_sel_r[CONV_CH_I - 3'h1] |=> IDEALITY_MILLI_O == 11'h3F0;
    endproperty
    a_ideal_default: assert property (p_ideal_default) else $error("default ideality wrong");

    property p_ideal_prog;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !is_local && ideal_sel_r[CONV_CH_I - 3'h1]
        |=> IDEALITY_MILLI_O == 11'h3E7 + 11'($past(ideality_r[4:0]));
    endproperty
    a_ideal_prog: assert property (p_ideal_prog) else $error("programmed ideality wrong");

    property p_ovt_clear;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && !over && clear_ok |=> !ovt_r[$past(ovt_bit)];
    endproperty
    a_ovt_clear: assert property (p_ovt_clear) else $error("overtemp not cleared");

    property p_fault_set;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        CONV_DONE_I && !is_local
        |=> fault_r[$past(CONV_CH_I) - 3'h1] == $past(DIODE_OPEN_I || ANODE_AT_SUPPLY_I);
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault bit wrong");

    property p_low_keep;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !low_rd |=> (low_r & $past(low_r)) == $past(low_r);
    endproperty
    a_low_keep: assert property (p_low_keep) else $error("low alert lost");

    property p_status_reset;
        @(posedge MCLK_I)
        !RST_N_I |=> ovt_r == STATUS_RESET && fault_r == STATUS_RESET && low_r == STATUS_RESET;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("status not reset");
endmodule

// ---- shared/tfs_pkg.sv ----
// constants for the temperature status-flag block
// assumes an 8-bit register port driven by the two-wire bus front end
package tfs_pkg;
    localparam int NCH = 8;
    localparam logic [7:0] OVT_STATUS_ADDR = 8'h45;
    localparam logic [7:0] DIODE_FAULT_ADDR = 8'h46;
    localparam logic [7:0] LOW_ALERT_ADDR = 8'h47;
    localparam logic [7:0] IDEALITY_ADDR = 8'h4B;
    localparam logic [7:0] IDEAL_SEL_ADDR = 8'h4C;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] IDEALITY_RESET = 8'h09;
    localparam logic [7:0] IDEAL_SEL_RESET = 8'h00;
    localparam logic [4:0] IDEAL_CODE_DEFAULT = 5'h09;
    localparam int IDEAL_CODE_W = 5;
    localparam logic [10:0] IDEAL_BASE_MILLI = 11'h3E7;
    localparam logic [10:0] HYST_DEG = 11'h020;
    localparam int LOCAL_CH = 0;
    localparam int OVT_LOCAL_BIT = 7;
    localparam int LOW_LOCAL_BIT = 6;
    localparam int FAULT_RSVD_BIT = 7;
endpackage

// ---- verif/tb_tfs_status_flags.sv ----
// self-checking bench for the status-flag block
// assumes the conversion model stands in for sequencer and diodes
`timescale 1ns/1ns
module tb_tfs_status_flags;
    import tfs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat;
    logic [10:0] idl, tmp, ovl, lwl;
    logic done, opn, sup;
    logic [2:0] ch;
    int err_total = 0;
    int n_tests = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    tfs_conv_model i_tfs_conv_model (.clk_i(clk), .done_o(done), .ch_o(ch), .temp_o(tmp),
        .ovt_o(ovl), .low_o(lwl), .open_o(opn), .sup_o(sup));
    tfs_status_flags i_tfs_status_flags (.MCLK_I(clk), .RST_N_I(rst_n), .CONV_DONE_I(done),
        .CONV_CH_I(ch), .CONV_TEMP_I(tmp), .OVT_LIMIT_I(ovl), .LOW_LIMIT_I(lwl),
        .DIODE_OPEN_I(opn), .ANODE_AT_SUPPLY_I(sup), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_RDATA_O(rdat), .IDEALITY_MILLI_O(idl));
    task chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(nm, {3'h0, rdat}, {3'h0, e});
    endtask
    task t_reset();
        rchk(OVT_STATUS_ADDR, 8'h00, "overtemp");
        rchk(DIODE_FAULT_ADDR, 8'h00, "fault");
        rchk(LOW_ALERT_ADDR, 8'h00, "low");
        rchk(8'h50, 8'h00, "unmapped");
    endtask
    task t_ovt();
        i_tfs_conv_model.conv(3'h0, 11'h0C8, 11'h064, 11'h000, 1'b0, 1'b0, 1'b1);
        rchk(OVT_STATUS_ADDR, 8'h80, "local over");
        i_tfs_conv_model.conv(3'h0, 11'h044, 11'h064, 11'h000, 1'b0, 1'b0, 1'b1);
        rchk(OVT_STATUS_ADDR, 8'h80, "band edge");
        i_tfs_conv_model.conv(3'h0, 11'h043, 11'h064, 11'h000, 1'b0, 1'b0, 1'b1);
        rchk(OVT_STATUS_ADDR, 8'h00, "below band");
        i_tfs_conv_model.conv(3'h0, 11'h0C8, 11'h064, 11'h000, 1'b0, 1'b0, 1'b1);
        rchk(OVT_STATUS_ADDR, 8'h80, "set again");
        i_tfs_conv_model.conv(3'h0, 11'h0C8, 11'h0E9, 11'h000, 1'b0, 1'b0, 1'b1);
        rchk(OVT_STATUS_ADDR, 8'h00, "limit raised");
    endtask
    task t_remote();
        for (logic [2:0] c = 3'h1; c != 3'h0; c++) begin
            i_tfs_conv_model.conv(c, 11'h0C8, 11'h064, 11'h12C, c[0], c == 3'h6, 1'b1);
        end
        rchk(OVT_STATUS_ADDR, 8'h7F, "remote over");
        rchk(DIODE_FAULT_ADDR, 8'h75, "fault map");
        rchk(LOW_ALERT_ADDR, 8'hBF, "remote low");
        rchk(LOW_ALERT_ADDR, 8'h00, "low after read");
        i_tfs_conv_model.conv(3'h3, 11'h0C8, 11'h064, 11'h12C, 1'b0, 1'b0, 1'b1);
        rchk(LOW_ALERT_ADDR, 8'h04, "low again");
        rchk(DIODE_FAULT_ADDR, 8'h71, "fault gone");
        i_tfs_conv_model.conv(3'h0, 11'h00A, 11'h1F4, 11'h014, 1'b0, 1'b0, 1'b1);
        rchk(LOW_ALERT_ADDR, 8'h40, "local low");
    endtask
    task t_ideal();
        wreg(IDEALITY_ADDR, 8'hFF);
        wreg(IDEAL_SEL_ADDR, 8'h04);
        i_tfs_conv_model.conv(3'h3, 11'h000, 11'h7FF, 11'h000, 1'b0, 1'b0, 1'b0);
        chk("programmed", idl, 11'h406);
        i_tfs_conv_model.conv(3'h2, 11'h000, 11'h7FF, 11'h000, 1'b0, 1'b0, 1'b0);
        chk("default", idl, 11'h3F0);
        wreg(IDEALITY_ADDR, 8'hE0);
        i_tfs_conv_model.conv(3'h3, 11'h000, 11'h7FF, 11'h000, 1'b0, 1'b0, 1'b0);
        chk("code zero", idl, 11'h3E7);
        rchk(IDEALITY_ADDR, 8'hE0, "ideality back");
        rchk(IDEAL_SEL_ADDR, 8'h04, "select back");
        wreg(OVT_STATUS_ADDR, 8'h00);
        rchk(OVT_STATUS_ADDR, 8'h7F, "status write ignored");
    endtask
    task t_rerst();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("rerun ideality", idl, 11'h3F0);
        t_reset();
        chk("select cleared", idl, 11'h3F0);
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        chk("reset ideality", idl, 11'h3F0);
        t_reset();
        t_ovt();
        t_remote();
        t_ideal();
        t_rerst();
        conclude();
    end
endmodule

// ---- verif/tfs_conv_model.sv ----
// conversion sequencer and remote diode detections for the flag block
// assumes the block samples these outputs on the rising edge of clk_i
`timescale 1ns/1ns
module tfs_conv_model (
    // clock
    input wire logic clk_i,
    // conversion result and diode state
    output logic done_o,
    output logic [2:0] ch_o,
    output logic [10:0] temp_o,
    output logic [10:0] ovt_o,
    output logic [10:0] low_o,
    output logic open_o,
    output logic sup_o
);
    initial begin
        {done_o, ch_o, temp_o, ovt_o, low_o, open_o, sup_o} = '0;
    end
    // one result; dn low only presents the channel
    task conv(input logic [2:0] c, input logic [10:0] t, input logic [10:0] ol,
        input logic [10:0] ll, input logic op, input logic su, input logic dn);
        @(negedge clk_i);
        ch_o = c;
        temp_o = t;
        ovt_o = ol;
        low_o = ll;
        open_o = op;
        sup_o = su;
        done_o = dn;
        @(negedge clk_i);
        done_o = 1'b0;
        // stale data must not look valid outside the pulse
        temp_o = ~t;
        {open_o, sup_o} = ~{op, su};
        @(negedge clk_i);
    endtask
endmodule
